//--- src/flash_mode_protect_erase_ctrl.sv
// flash device end: mode select, boot protection, lockout status, chip erase
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module flash_mode_protect_erase_ctrl
    import flash_ctrl_pkg::*;
#(
    parameter int ERASE_CYC = ERASE_CYCLES
)(
    input wire logic clk_sys,
    input wire logic rst,
    flash_link_if.dev link,
    output logic [18:0] arr_addr,
    input wire logic [7:0] arr_rdata,
    output logic arr_erase,
    output logic arr_erase_main,
    output logic arr_erase_boot,
    output logic [18:0] arr_boot_base,
    output logic prog_mode,
    output logic busy
);
    logic cap_q;
    logic prog_mode_q;
    logic tbl_n_q;
    logic wp_n_q;
    logic active;
    logic [7:0] row_q;
    logic [10:0] col_q;
    logic we_q;
    logic oe_q;
    logic [3:0] hub_cnt_q;
    logic hub_wr_q;
    logic [19:0] hub_addr_q;
    logic [3:0] hub_lo_q;
    logic [3:0] hub_hi_q;
    logic [3:0] nib_out_q;
    logic nib_oe_q;
    logic [7:0] dq_out_q;
    logic [18:0] cur_addr;
    logic [7:0] rv;
    logic pgm_wr;
    logic pgm_rd_end;
    logic hub_wr;
    logic hub_rd_end;
    logic wr_fire;
    logic [7:0] wr_data;
    logic at_u1;
    logic at_u2;
    seq_e seq_q;
    logic id_q;
    logic lock64_q;
    logic lock16_q;
    logic boot_prot;
    logic main_prot;
    logic erase_go;
    logic busy_q;
    logic [31:0] erase_cnt_q;
    logic toggle_q;
    logic arr_erase_q;
    logic erase_main_q;
    logic erase_boot_q;
    logic [18:0] boot_base_q;

    function automatic logic [7:0] read_value(input logic [18:0] a, input logic [7:0] d,
        input logic bsy, input logic tgl, input logic idm, input logic [3:0] st);
        if (bsy)
            read_value = {~d[7], tgl, d[5:0]};
        else if (idm && a == BOOT_LOCK_STATUS_ADDR)
            read_value = {4'h0, st};
        else if (idm)
            read_value = 8'h00;
        else
            read_value = d;
    endfunction : read_value

    // pins taken on the first cycle after reset is released
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cap_q <= 1'b1;
        else
            cap_q <= ~link.reset_n;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            prog_mode_q <= 1'b0;
            tbl_n_q <= 1'b1;
            wp_n_q <= 1'b1;
        end
        else if (link.reset_n && cap_q)
        begin
            prog_mode_q <= link.interface_select;
            tbl_n_q <= link.top_boot_lock_n;
            wp_n_q <= link.write_protect_n;
        end
    end

    assign active = link.reset_n & ~cap_q;
    assign cur_addr = prog_mode_q ? {row_q, col_q} : hub_addr_q[18:0];
    assign arr_addr = cur_addr;
    assign rv = read_value(cur_addr, arr_rdata, busy_q, toggle_q, id_q,
        {~wp_n_q, ~tbl_n_q, lock16_q, lock64_q});

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            row_q <= 8'h00;
            col_q <= 11'h000;
            we_q <= 1'b1;
            oe_q <= 1'b1;
            dq_out_q <= 8'h00;
        end
        else
        begin
            we_q <= link.we_n;
            oe_q <= link.oe_n;
            dq_out_q <= rv;
            if (link.row_col_sel)
                row_q <= link.addr_pins[7:0];
            else
                col_q <= link.addr_pins;
        end
    end

    // a write is taken when the strobe rises, data still held by the host
    assign pgm_wr = active & prog_mode_q & ~we_q & link.we_n;
    assign pgm_rd_end = active & prog_mode_q & ~oe_q & link.oe_n;
    assign link.dq_dev_out = dq_out_q;
    assign link.dq_dev_oe = active & prog_mode_q & ~link.oe_n;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            hub_cnt_q <= HUB_C_IDLE;
            hub_wr_q <= 1'b0;
            hub_addr_q <= 20'h00000;
            hub_lo_q <= 4'h0;
            hub_hi_q <= 4'h0;
            nib_out_q <= 4'h0;
            nib_oe_q <= 1'b0;
        end
        else if (!active || prog_mode_q)
        begin
            hub_cnt_q <= HUB_C_IDLE;
            nib_oe_q <= 1'b0;
        end
        else
        begin
            case (hub_cnt_q)
                HUB_C_IDLE:
                begin
                    if (!link.cycle_frame_input_n && (link.nibble_bus_lines[1:0] ==
                        HUB_DIR_READ || link.nibble_bus_lines[1:0] == HUB_DIR_WRITE))
                    begin
                        hub_cnt_q <= 4'h1;
                        hub_wr_q <= link.nibble_bus_lines[1:0] == HUB_DIR_WRITE;
                    end
                end
                HUB_C_DATA0:
                begin
                    hub_cnt_q <= HUB_C_DATA1;
                    if (hub_wr_q)
                        hub_lo_q <= link.nibble_bus_lines;
                    else
                    begin
                        nib_out_q <= rv[3:0];
                        hub_hi_q <= rv[7:4];
                        nib_oe_q <= 1'b1;
                    end
                end
                HUB_C_DATA1:
                begin
                    if (hub_wr_q)
                        hub_cnt_q <= HUB_C_IDLE;
                    else
                    begin
                        hub_cnt_q <= HUB_C_DATA2;
                        nib_out_q <= hub_hi_q;
                    end
                end
                HUB_C_DATA2:
                begin
                    hub_cnt_q <= HUB_C_IDLE;
                    nib_oe_q <= 1'b0;
                end
                default:
                begin
                    hub_addr_q <= {hub_addr_q[15:0], link.nibble_bus_lines};
                    hub_cnt_q <= hub_cnt_q + 4'h1;
                end
            endcase
        end
    end

    assign hub_wr = active & ~prog_mode_q & hub_wr_q & (hub_cnt_q == HUB_C_DATA1);
    assign hub_rd_end = active & ~prog_mode_q & (hub_cnt_q == HUB_C_DATA2);
    assign link.nib_dev_out = nib_out_q;
    assign link.nib_dev_oe = nib_oe_q & active;

    // command sequencer; writes during an erase are ignored
    assign wr_fire = (pgm_wr | hub_wr) & ~busy_q;
    assign wr_data = prog_mode_q ? link.dq_bus : {link.nibble_bus_lines, hub_lo_q};
    assign at_u1 = cur_addr[14:0] == UNLOCK1_ADDR;
    assign at_u2 = cur_addr[14:0] == UNLOCK2_ADDR;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            seq_q <= SEQ_IDLE;
            id_q <= 1'b0;
            lock64_q <= 1'b0;
            lock16_q <= 1'b0;
        end
        else if (!active)
        begin
            seq_q <= SEQ_IDLE;
            id_q <= 1'b0;
        end
        else if (wr_fire)
        begin
            seq_q <= SEQ_IDLE;
            case (seq_q)
                SEQ_IDLE:
                begin
                    if (wr_data == CMD_UNLOCK1 && at_u1)
                        seq_q <= SEQ_U1;
                    else if (wr_data == CMD_ID_EXIT)
                        id_q <= 1'b0;
                end
                SEQ_U1:
                    if (wr_data == CMD_UNLOCK2 && at_u2)
                        seq_q <= SEQ_U2;
                SEQ_U2:
                begin
                    if (wr_data == CMD_SETUP && at_u1)
                        seq_q <= SEQ_U3;
                    else if (wr_data == CMD_ID_ENTER && at_u1)
                        id_q <= 1'b1;
                    else if (wr_data == CMD_ID_EXIT && at_u1)
                        id_q <= 1'b0;
                end
                SEQ_U3:
                    if (wr_data == CMD_UNLOCK1 && at_u1)
                        seq_q <= SEQ_U4;
                SEQ_U4:
                    if (wr_data == CMD_UNLOCK2 && at_u2)
                        seq_q <= SEQ_CONFIRM;
                SEQ_CONFIRM:
                begin
                    if (wr_data == CMD_LOCK64 && at_u1)
                        lock64_q <= 1'b1;
                    else if (wr_data == CMD_LOCK16 && at_u1)
                        lock16_q <= 1'b1;
                end
                default:
                    seq_q <= SEQ_IDLE;
            endcase
        end
    end

    assign erase_go = wr_fire & (seq_q == SEQ_CONFIRM) & at_u1 &
        (wr_data == CMD_CHIP_ERASE);
    // the pin always guards the full 64K, whatever the software size
    assign boot_prot = ~tbl_n_q | lock64_q | lock16_q;
    assign main_prot = ~wp_n_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            busy_q <= 1'b0;
            erase_cnt_q <= 32'h0;
        end
        else if (!active)
            busy_q <= 1'b0;
        else if (erase_go && !(boot_prot && main_prot))
        begin
            busy_q <= 1'b1;
            erase_cnt_q <= 32'h0;
        end
        else if (busy_q)
        begin
            if (erase_cnt_q == 32'(ERASE_CYC - 1))
                busy_q <= 1'b0;
            else
                erase_cnt_q <= erase_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            arr_erase_q <= 1'b0;
            erase_main_q <= 1'b0;
            erase_boot_q <= 1'b0;
            boot_base_q <= BOOT64_BASE;
        end
        else
        begin
            arr_erase_q <= erase_go & ~(boot_prot & main_prot) & active;
            if (erase_go)
            begin
                erase_main_q <= ~main_prot;
                erase_boot_q <= ~boot_prot;
                boot_base_q <= (~tbl_n_q | lock64_q) ? BOOT64_BASE : BOOT16_BASE;
            end
        end
    end

    // toggle advances once per completed read while busy
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            toggle_q <= 1'b0;
        else if (!busy_q)
            toggle_q <= 1'b0;
        else if (pgm_rd_end || hub_rd_end)
            toggle_q <= ~toggle_q;
    end

    assign arr_erase = arr_erase_q;
    assign arr_erase_main = erase_main_q;
    assign arr_erase_boot = erase_boot_q;
    assign arr_boot_base = boot_base_q;
    assign prog_mode = prog_mode_q;
    assign busy = busy_q;
endmodule : flash_mode_protect_erase_ctrl

//--- src/flash_ctrl_pkg.sv
// shared constants and types for the flash controller and its host
package flash_ctrl_pkg;
    localparam int A_W = 19;
    localparam logic [18:0] BOOT64_BASE = 19'h70000;
    localparam logic [18:0] BOOT16_BASE = 19'h7c000;
    localparam logic [18:0] BOOT_LOCK_STATUS_ADDR = 19'h7fff2;
    localparam logic [14:0] UNLOCK1_ADDR = 15'h5555;
    localparam logic [14:0] UNLOCK2_ADDR = 15'h2aaa;
    localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_SETUP = 8'h80;
    localparam logic [7:0] CMD_ID_ENTER = 8'h90;
    localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_LOCK64 = 8'h40;
    localparam logic [7:0] CMD_LOCK16 = 8'h70;
    localparam int CHIP_ERASE_MS = 100;
    localparam int CLK_MHZ = 200;
    localparam int ERASE_CYCLES = CHIP_ERASE_MS * CLK_MHZ * 1000;
    localparam logic [1:0] HUB_DIR_READ = 2'h1;
    localparam logic [1:0] HUB_DIR_WRITE = 2'h2;
    localparam logic [3:0] HUB_C_IDLE = 4'h0;
    localparam logic [3:0] HUB_C_DATA0 = 4'h6;
    localparam logic [3:0] HUB_C_DATA1 = 4'h7;
    localparam logic [3:0] HUB_C_DATA2 = 4'h8;
    localparam logic [2:0] HUB_ADDR_LAST = 3'h4;
    localparam logic [2:0] PGM_PHASE_CYC = 3'h2;
    localparam logic [2:0] PGM_STROBE_CYC = 3'h3;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_WDATA = 4'h2;
    localparam logic [3:0] REG_GO = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] CTRL_RESET = 4'hc;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_U1 = 3'b001,
        SEQ_U2 = 3'b010,
        SEQ_U3 = 3'b011,
        SEQ_U4 = 3'b100,
        SEQ_CONFIRM = 3'b101
    } seq_e;

    typedef enum logic [3:0] {
        H_IDLE = 4'b0000,
        H_ROW = 4'b0001,
        H_COL = 4'b0010,
        H_STROBE = 4'b0011,
        H_REL = 4'b0100,
        H_START = 4'b0101,
        H_ADDR = 4'b0110,
        H_DATA = 4'b0111,
        H_TAR = 4'b1000,
        H_RDATA = 4'b1001
    } host_state_e;
endpackage : flash_ctrl_pkg

//--- src/flash_link_if.sv
// pins between the flash device end and the host end, with bus resolution
`timescale 1ns/1ps
interface flash_link_if;
    logic interface_select;
    logic reset_n;
    logic top_boot_lock_n;
    logic write_protect_n;
    logic row_col_sel;
    logic [10:0] addr_pins;
    logic oe_n;
    logic we_n;
    logic [7:0] dq_host_out;
    logic dq_host_oe;
    logic [7:0] dq_dev_out;
    logic dq_dev_oe;
    logic [7:0] dq_bus;
    logic cycle_frame_input_n;
    logic [3:0] nib_host_out;
    logic nib_host_oe;
    logic [3:0] nib_dev_out;
    logic nib_dev_oe;
    logic [3:0] nibble_bus_lines;

    // undriven lines float high, as with a pull-up
    assign dq_bus = dq_dev_oe ? dq_dev_out : (dq_host_oe ? dq_host_out : 8'hff);
    assign nibble_bus_lines = nib_dev_oe ? nib_dev_out :
        (nib_host_oe ? nib_host_out : 4'hf);

    modport dev (
        input interface_select, reset_n, top_boot_lock_n, write_protect_n,
        input row_col_sel, addr_pins, oe_n, we_n, dq_bus,
        input cycle_frame_input_n, nibble_bus_lines,
        output dq_dev_out, dq_dev_oe, nib_dev_out, nib_dev_oe
    );
    modport host (
        output interface_select, reset_n, top_boot_lock_n, write_protect_n,
        output row_col_sel, addr_pins, oe_n, we_n, dq_host_out, dq_host_oe,
        output cycle_frame_input_n, nib_host_out, nib_host_oe,
        input dq_bus, nibble_bus_lines
    );
endinterface : flash_link_if

//--- src/flash_prog_host.sv
// host end: drives the flash pins in programmer or hub mode from a register port
`timescale 1ns/1ps
module flash_prog_host
    import flash_ctrl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    flash_link_if.host link
);
    logic [3:0] ctrl_q;
    logic [18:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic [31:0] reg_rdata_q;
    logic xfer_wr_q;
    host_state_e state_q;
    logic [2:0] cnt_q;
    logic go;
    logic [19:0] addr20;

    function automatic logic [3:0] nibble_of(input logic [19:0] a, input logic [2:0] idx);
        case (idx)
            3'h0: nibble_of = a[19:16];
            3'h1: nibble_of = a[15:12];
            3'h2: nibble_of = a[11:8];
            3'h3: nibble_of = a[7:4];
            default: nibble_of = a[3:0];
        endcase
    endfunction : nibble_of

    assign go = reg_wr && reg_addr == REG_GO && state_q == H_IDLE && ctrl_q[0];
    assign addr20 = {1'b0, addr_q};

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= CTRL_RESET;
            addr_q <= 19'h00000;
            wdata_q <= 8'h00;
            xfer_wr_q <= 1'b0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                REG_CTRL:
                begin
                    ctrl_q[0] <= reg_wdata[0];
                    // strap pins may only change while the device is held in reset
                    if (!ctrl_q[0])
                        ctrl_q[3:1] <= reg_wdata[3:1];
                end
                REG_ADDR: addr_q <= reg_wdata[18:0];
                REG_WDATA: wdata_q <= reg_wdata[7:0];
                REG_GO: if (go) xfer_wr_q <= reg_wdata[0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            reg_rdata_q <= 32'h0;
        else if (reg_rd)
        begin
            case (reg_addr)
                REG_CTRL: reg_rdata_q <= {28'h0, ctrl_q};
                REG_ADDR: reg_rdata_q <= {13'h0, addr_q};
                REG_WDATA: reg_rdata_q <= {24'h0, wdata_q};
                REG_STATUS: reg_rdata_q <= {16'h0, rdata_q, 7'h0, state_q != H_IDLE};
                default: reg_rdata_q <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_q <= H_IDLE;
            cnt_q <= 3'h0;
            rdata_q <= 8'h00;
        end
        else if (!ctrl_q[0])
            state_q <= H_IDLE;
        else
        begin
            cnt_q <= cnt_q + 3'h1;
            case (state_q)
                H_IDLE:
                begin
                    cnt_q <= 3'h0;
                    if (go)
                        state_q <= ctrl_q[1] ? H_ROW : H_START;
                end
                H_ROW:
                    if (cnt_q == PGM_PHASE_CYC - 3'h1)
                    begin
                        state_q <= H_COL;
                        cnt_q <= 3'h0;
                    end
                H_COL:
                    if (cnt_q == PGM_PHASE_CYC - 3'h1)
                    begin
                        state_q <= H_STROBE;
                        cnt_q <= 3'h0;
                    end
                H_STROBE:
                    if (cnt_q == PGM_STROBE_CYC - 3'h1)
                    begin
                        state_q <= H_REL;
                        if (!xfer_wr_q)
                            rdata_q <= link.dq_bus;
                    end
                H_REL: state_q <= H_IDLE;
                H_START:
                begin
                    state_q <= H_ADDR;
                    cnt_q <= 3'h0;
                end
                H_ADDR:
                    if (cnt_q == HUB_ADDR_LAST)
                    begin
                        state_q <= xfer_wr_q ? H_DATA : H_TAR;
                        cnt_q <= 3'h0;
                    end
                H_DATA:
                    if (cnt_q == 3'h1)
                        state_q <= H_IDLE;
                H_TAR:
                begin
                    state_q <= H_RDATA;
                    cnt_q <= 3'h0;
                end
                H_RDATA:
                begin
                    if (cnt_q == 3'h0)
                        rdata_q[3:0] <= link.nibble_bus_lines;
                    else
                    begin
                        rdata_q[7:4] <= link.nibble_bus_lines;
                        state_q <= H_IDLE;
                    end
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign link.reset_n = ctrl_q[0];
    assign link.interface_select = ctrl_q[1];
    assign link.top_boot_lock_n = ctrl_q[2];
    assign link.write_protect_n = ctrl_q[3];
    assign link.row_col_sel = state_q == H_ROW;
    assign link.addr_pins = (state_q == H_ROW) ? {3'h0, addr_q[18:11]} : addr_q[10:0];
    assign link.we_n = ~(state_q == H_STROBE && xfer_wr_q);
    assign link.oe_n = ~(state_q == H_STROBE && !xfer_wr_q);
    assign link.dq_host_out = wdata_q;
    assign link.dq_host_oe = xfer_wr_q && (state_q == H_STROBE || state_q == H_REL);
    assign link.cycle_frame_input_n = state_q != H_START;
    assign link.nib_host_oe = state_q == H_START || state_q == H_ADDR || state_q == H_DATA;
    assign link.nib_host_out = (state_q == H_START) ?
        {2'h0, xfer_wr_q ? HUB_DIR_WRITE : HUB_DIR_READ} :
        (state_q == H_DATA) ? ((cnt_q == 3'h0) ? wdata_q[3:0] : wdata_q[7:4]) :
        nibble_of(addr20, cnt_q);
endmodule : flash_prog_host

//--- testbench/flash_link_monitor.sv
// pin-level checks between the host and device ends
`timescale 1ns/1ps
module flash_link_monitor (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reset_n,
    input wire logic interface_select,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic dq_dev_oe,
    input wire logic dq_host_oe,
    input wire logic nib_dev_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_strobe;
        !we_n [*3] ##1 we_n;
    endsequence
    sequence s_nib_pair;
        nib_dev_oe ##1 !nib_dev_oe;
    endsequence
    a_dq_gated: assert property (dq_dev_oe |-> !oe_n && interface_select)
        else $error("data driven without enable");
    a_oe_answer: assert property (interface_select && !oe_n && $past(reset_n, 2)
        && reset_n |-> dq_dev_oe) else $error("no data on enable");
    a_reset_quiet: assert property (!reset_n |-> !dq_dev_oe && !nib_dev_oe)
        else $error("driving in reset");
    a_resume_quiet: assert property ($rose(reset_n) |-> !dq_dev_oe && !nib_dev_oe)
        else $error("driving on reset exit");
    a_no_fight: assert property (!(dq_dev_oe && dq_host_oe))
        else $error("data bus contention");
    a_write_len: assert property ($fell(we_n) |-> s_strobe)
        else $error("write strobe length");
    a_nib_pair: assert property ($rose(nib_dev_oe) |=> s_nib_pair)
        else $error("hub read nibble count");
    a_nib_mode: assert property (nib_dev_oe |-> !interface_select && reset_n)
        else $error("hub drive in wrong mode");
endmodule : flash_link_monitor

//--- testbench/flash_mode_protect_erase_ctrl_test.sv
// end-to-end bench: host register port drives the device over the pin link
`timescale 1ns/1ps
module flash_mode_protect_erase_ctrl_test;
    import flash_ctrl_pkg::*;
    localparam int ECYC = 50;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, rv;
    logic [18:0] arr_addr, arr_boot_base;
    logic [7:0] arr_rdata;
    logic arr_erase, arr_erase_main, arr_erase_boot, prog_mode, busy, t;
    int err_count = 0;
    int n_checks = 0;
    int erase_n = 0;
    flash_link_if link ();
    flash_prog_host flash_prog_host_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .link(link.host));
    flash_mode_protect_erase_ctrl #(.ERASE_CYC(ECYC)) flash_mode_protect_erase_ctrl_i (
        .clk_sys(clk_sys), .rst(rst), .link(link.dev), .arr_addr(arr_addr),
        .arr_rdata(arr_rdata), .arr_erase(arr_erase), .arr_erase_main(arr_erase_main),
        .arr_erase_boot(arr_erase_boot), .arr_boot_base(arr_boot_base),
        .prog_mode(prog_mode), .busy(busy));
    flash_link_monitor flash_link_monitor_i (.clk_sys(clk_sys), .rst(rst),
        .reset_n(link.reset_n), .interface_select(link.interface_select), .oe_n(link.oe_n),
        .we_n(link.we_n), .dq_dev_oe(link.dq_dev_oe), .dq_host_oe(link.dq_host_oe),
        .nib_dev_oe(link.nib_dev_oe));
    // array stand-in mixes row and column bits so a swapped half shows
    assign arr_rdata = arr_addr[7:0] ^ arr_addr[18:11];
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (arr_erase === 1'b1) erase_n <= erase_n + 1;
    task automatic chk(input string nm, input logic [18:0] exp, input logic [18:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic go(input logic w);
        int i;
        wr(REG_GO, {31'h0, w});
        for (i = 0; i < 40; i++)
        begin
            reg_addr <= REG_STATUS;
            reg_rd <= 1'b1;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            @(posedge clk_sys);
            rv = reg_rdata;
            if (rv[0] !== 1'b1) break;
        end
    endtask : go
    task automatic xfer(input logic [18:0] a, input logic [7:0] d, input logic w);
        wr(REG_ADDR, {13'h0, a});
        wr(REG_WDATA, {24'h0, d});
        go(w);
    endtask : xfer
    task automatic unlock(input logic [7:0] c);
        xfer({4'h0, UNLOCK1_ADDR}, CMD_UNLOCK1, 1'b1);
        xfer({4'h0, UNLOCK2_ADDR}, CMD_UNLOCK2, 1'b1);
        xfer({4'h0, UNLOCK1_ADDR}, c, 1'b1);
    endtask : unlock
    task automatic long_cmd(input logic [7:0] c);
        unlock(CMD_SETUP);
        unlock(c);
    endtask : long_cmd
    // straps only move while the device is held in reset
    task automatic set_pins(input logic [3:0] c);
        wr(REG_CTRL, {28'h0, c & 4'he});
        wr(REG_CTRL, {28'h0, c});
        repeat (2) @(posedge clk_sys);
    endtask : set_pins
    task automatic id_and_lock();
        set_pins(4'hb);
        chk("prog_mode", 1'b1, prog_mode);
        unlock(CMD_ID_ENTER);
        xfer(BOOT_LOCK_STATUS_ADDR, 8'h0, 1'b0);
        chk("lock status", 8'h04, rv[15:8]);
        xfer(19'h0, CMD_ID_EXIT, 1'b1);
        xfer(19'h2d3c5, 8'h0, 1'b0);
        chk("array read", 8'h9f, rv[15:8]);
        // 16K software lock, so only the pin can make the erase keep 64K
        long_cmd(CMD_LOCK16);
        unlock(CMD_ID_ENTER);
        xfer(BOOT_LOCK_STATUS_ADDR, 8'h0, 1'b0);
        chk("lock status", 8'h06, rv[15:8]);
        unlock(CMD_ID_EXIT);
    endtask : id_and_lock
    task automatic chip_erase();
        long_cmd(CMD_CHIP_ERASE);
        chk("busy", 1'b1, busy);
        go(1'b0);
        chk("polling bit", 1'b1, rv[15]);
        t = rv[14];
        go(1'b0);
        chk("toggle bit", {18'h0, ~t}, rv[14]);
        repeat (ECYC) @(posedge clk_sys);
        go(1'b0);
        chk("read after erase", 8'h5f, rv[15:8]);
        chk("erase count", 19'h1, erase_n[18:0]);
        chk("erase main", 1'b1, arr_erase_main);
        chk("erase boot", 1'b0, arr_erase_boot);
        chk("boot base", BOOT64_BASE, arr_boot_base);
    endtask : chip_erase
    task automatic hub_refuse();
        set_pins(4'h5);
        chk("prog_mode", 1'b0, prog_mode);
        xfer(19'h2d3c5, 8'h0, 1'b0);
        chk("hub read", 8'h9f, rv[15:8]);
        long_cmd(CMD_LOCK64);
        unlock(CMD_ID_ENTER);
        xfer(BOOT_LOCK_STATUS_ADDR, 8'h0, 1'b0);
        chk("hub lock status", 8'h0b, rv[15:8]);
        long_cmd(CMD_CHIP_ERASE);
        chk("busy", 1'b0, busy);
        chk("erase count", 19'h1, erase_n[18:0]);
    endtask : hub_refuse
    task automatic results();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        id_and_lock();
        chip_erase();
        hub_refuse();
        results();
    end
    initial
    begin
        #50000;
        err_count++;
        results();
    end
endmodule : flash_mode_protect_erase_ctrl_test
